// [logic/usid_ir_demod.sv]
// Infrared receive filter: stretches a short low pulse into one bit time
// Assumes the receive line is synchronous to the system clock
`timescale 1ns/1ps
`default_nettype none
module usid_ir_demod (
  input  wire logic                         clk_i,
  input  wire logic                         rstn_i,
  input  wire logic                         ir_en_i,
  input  wire logic                         rxd_i,
  input  wire logic [usid_pkg::IRFILT_W-1:0] filt_i,
  input  wire logic [usid_pkg::BAUD_W-1:0]   baud_i,
  output logic                              rxd_o
);

  usid_pkg::usid_dm_e             st_q;
  logic [usid_pkg::IRFILT_W-1:0] cnt_q;
  logic [usid_pkg::BAUD_W-1:0]   bit_q;
  logic                          rxd_q;
  logic                          fall;
  logic                          rise;

  assign fall = rxd_q & ~rxd_i;
  assign rise = ~rxd_q & rxd_i;

  // ==========================================================================
  // Filter counter and stretched output
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st_q  <= usid_pkg::DM_IDLE;
      cnt_q <= usid_pkg::RST_IRFILT;
      bit_q <= usid_pkg::RST_BAUD;
      rxd_q <= 1'b1;
      rxd_o <= 1'b1;
    end else begin
      rxd_q <= rxd_i;
      if (!ir_en_i) begin
        st_q  <= usid_pkg::DM_IDLE;
        cnt_q <= filt_i;
        rxd_o <= rxd_i;
      end else begin
        case (st_q)
          usid_pkg::DM_IDLE: begin
            rxd_o <= 1'b1;
            cnt_q <= filt_i;
            if (fall) begin
              st_q <= usid_pkg::DM_COUNT;
            end
          end
          usid_pkg::DM_COUNT: begin
            if (rise) begin
              st_q  <= usid_pkg::DM_IDLE;
              cnt_q <= filt_i;
            end else if (cnt_q == '0) begin
              st_q  <= usid_pkg::DM_LOW;
              rxd_o <= 1'b0;
              bit_q <= baud_i;
            end else begin
              cnt_q <= cnt_q - 1'b1;
            end
          end
          usid_pkg::DM_LOW: begin
            if (bit_q <= 11'h001) begin
              st_q  <= usid_pkg::DM_IDLE;
              rxd_o <= 1'b1;
            end else begin
              bit_q <= bit_q - 1'b1;
            end
          end
          default: begin
            st_q <= usid_pkg::DM_IDLE;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Checks
  logic [usid_pkg::BAUD_W-1:0] low_cnt_q;
  always_ff @(posedge clk_i) begin
    if (!rstn_i || rxd_o) begin
      low_cnt_q <= '0;
    end else begin
      low_cnt_q <= low_cnt_q + 1'b1;
    end
  end

  a_filt_load: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ir_en_i && st_q == usid_pkg::DM_IDLE && fall |=> cnt_q == $past(filt_i))
    else $error("filter counter not loaded with filter value");
  a_count_down: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ir_en_i && st_q == usid_pkg::DM_COUNT && !rise && cnt_q != '0
    |=> cnt_q == $past(cnt_q) - 8'h01)
    else $error("filter counter did not decrement");
  a_rise_stop: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ir_en_i && st_q == usid_pkg::DM_COUNT && rise
    |=> st_q == usid_pkg::DM_IDLE && rxd_o)
    else $error("rising edge did not stop the filter");
  a_low_len: assert property (@(posedge clk_i) disable iff (!rstn_i)
    ir_en_i && $rose(rxd_o) && $past(st_q) == usid_pkg::DM_LOW
    |-> low_cnt_q == (baud_i == '0 ? 11'h001 : baud_i))
    else $error("demodulated low not one bit time");
  c_pulse: cover property (@(posedge clk_i) disable iff (!rstn_i)
    ir_en_i && $rose(rxd_o) && $past(st_q) == usid_pkg::DM_LOW);

endmodule : usid_ir_demod
`default_nettype wire

// [logic/usid_pkg.sv]
// Constants shared by the serial status and infrared demodulator block
// Assumes a single 100 MHz system clock and an APB register port
package usid_pkg;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_CMD    = 8'h00;
  localparam logic [7:0] OFF_MODE   = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_MASK   = 8'h0C;
  localparam logic [7:0] OFF_IRFILT = 8'h10;
  localparam logic [7:0] OFF_BAUD   = 8'h14;
  localparam logic [7:0] OFF_TOVAL  = 8'h18;

  // ==========================================================================
  // Command bits of the control register (write-only)
  localparam int CMD_CLR_STATUS = 8;
  localparam int CMD_START_TO   = 11;
  localparam int CMD_CLR_NACK   = 14;

  // ==========================================================================
  // Mode register fields
  localparam int MODE_OP_LSB  = 0;
  localparam int MODE_OP_W    = 4;
  localparam int MODE_IR_BIT  = 4;
  localparam int MODE_TXE_BIT = 5;
  localparam logic [3:0] OP_SPI_SLAVE = 4'hF;

  // ==========================================================================
  // Channel status bits (mask register has the same layout)
  localparam int ST_PARITY = 0;
  localparam int ST_TO     = 1;
  localparam int ST_TXE    = 2;
  localparam int ST_REPEAT = 3;
  localparam int ST_URUN   = 4;
  localparam int ST_TXDMA  = 5;
  localparam int ST_RXDMA  = 6;
  localparam int ST_NACK   = 7;
  localparam int ST_CHG    = 8;
  localparam int ST_W      = 11;

  // ==========================================================================
  // Field widths and reset values
  localparam int IRFILT_W = 8;
  localparam int BAUD_W   = 11;
  localparam int TOVAL_W  = 16;
  localparam logic [5:0]          RST_MODE   = 6'h00;
  localparam logic [ST_W-1:0]     RST_MASK   = 11'h000;
  localparam logic [IRFILT_W-1:0] RST_IRFILT = 8'h00;
  localparam logic [BAUD_W-1:0]   RST_BAUD   = 11'h010;
  localparam logic [TOVAL_W-1:0]  RST_TOVAL  = 16'h0000;

  // ==========================================================================
  // Demodulator states
  typedef enum logic [1:0] {
    DM_IDLE  = 2'b00,
    DM_COUNT = 2'b01,
    DM_LOW   = 2'b10
  } usid_dm_e;

endpackage : usid_pkg

// [logic/usid_top.sv]
// Serial channel status flags and infrared demodulator with APB registers
// Assumes APB master on CLK_SYS_I and all event inputs synchronous to it
//
// Contract
// - Filter uses 8-bit down counter from setting
// - Falling edge starts countdown each clock
// - Rising edge stops and reloads counter
// - Counter zero drives receiver low one bit
// - Parity flag sticky until clear-status command
// - Timeout flag after start; zero value reads 0
// - Tx empty needs both empty, enabled
// - Repetition flag sticky until clear-status command
// - Underrun only in SPI slave, sticky
// - Tx buffer-empty bit mirrors DMA signal
// - Rx buffer-full bit mirrors DMA signal
// - Nack flag sticky until clear-nack command
// - Ring change flag, cleared by status read
// - DSR change flag, cleared by status read
// - DCD change flag, cleared by status read
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module usid_top (
  input  wire logic        CLK_SYS_I,
  input  wire logic        RSTN_I,
  input  wire logic        PSEL_I,
  input  wire logic        PENABLE_I,
  input  wire logic        PWRITE_I,
  input  wire logic [7:0]  PADDR_I,
  input  wire logic [31:0] PWDATA_I,
  output logic      [31:0] PRDATA_O,
  output logic             PREADY_O,
  output logic             PSLVERR_O,
  input  wire logic        PARITY_ERR_I,
  input  wire logic        TIMEOUT_EVT_I,
  input  wire logic        REPEAT_EVT_I,
  input  wire logic        UNDERRUN_I,
  input  wire logic        NACK_I,
  input  wire logic        THR_EMPTY_I,
  input  wire logic        TSR_EMPTY_I,
  input  wire logic        TX_DMA_BUF_EMPTY_I,
  input  wire logic        RX_DMA_BUF_FULL_I,
  input  wire logic        RING_I,
  input  wire logic        DSR_I,
  input  wire logic        DCD_I,
  input  wire logic        RXD_I,
  output logic             RXD_DEMOD_O,
  output logic             TX_ENABLE_O,
  output logic             IR_MODE_O,
  output logic [3:0]       OP_MODE_O,
  output logic [15:0]      TIMEOUT_VAL_O,
  output logic             IRQ_O
);

  // ==========================================================================
  // Address decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  logic mapped;
  logic acc;
  logic wr;
  logic rd_setup;
  logic wr_cmd;

  assign mapped = hit(PADDR_I, usid_pkg::OFF_CMD)    | hit(PADDR_I, usid_pkg::OFF_MODE)
                | hit(PADDR_I, usid_pkg::OFF_STATUS) | hit(PADDR_I, usid_pkg::OFF_MASK)
                | hit(PADDR_I, usid_pkg::OFF_IRFILT) | hit(PADDR_I, usid_pkg::OFF_BAUD)
                | hit(PADDR_I, usid_pkg::OFF_TOVAL);
  assign acc      = PSEL_I & PENABLE_I;
  assign wr       = acc & PWRITE_I & mapped;
  assign rd_setup = PSEL_I & ~PENABLE_I & ~PWRITE_I;
  assign wr_cmd   = wr & hit(PADDR_I, usid_pkg::OFF_CMD);

  assign PREADY_O  = 1'b1;
  assign PSLVERR_O = acc & ~mapped;

  // ==========================================================================
  // Configuration registers
  logic [5:0]                    mode_q;
  logic [usid_pkg::ST_W-1:0]     mask_q;
  logic [usid_pkg::IRFILT_W-1:0] irfilt_q;
  logic [usid_pkg::BAUD_W-1:0]   baud_q;
  logic [usid_pkg::TOVAL_W-1:0]  toval_q;

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      mode_q   <= usid_pkg::RST_MODE;
      mask_q   <= usid_pkg::RST_MASK;
      irfilt_q <= usid_pkg::RST_IRFILT;
      baud_q   <= usid_pkg::RST_BAUD;
      toval_q  <= usid_pkg::RST_TOVAL;
    end else if (wr) begin
      if (hit(PADDR_I, usid_pkg::OFF_MODE)) begin
        mode_q <= PWDATA_I[5:0];
      end
      if (hit(PADDR_I, usid_pkg::OFF_MASK)) begin
        mask_q <= PWDATA_I[usid_pkg::ST_W-1:0];
      end
      if (hit(PADDR_I, usid_pkg::OFF_IRFILT)) begin
        irfilt_q <= PWDATA_I[usid_pkg::IRFILT_W-1:0];
      end
      if (hit(PADDR_I, usid_pkg::OFF_BAUD)) begin
        baud_q <= PWDATA_I[usid_pkg::BAUD_W-1:0];
      end
      if (hit(PADDR_I, usid_pkg::OFF_TOVAL)) begin
        toval_q <= PWDATA_I[usid_pkg::TOVAL_W-1:0];
      end
    end
  end

  logic [3:0] op_mode;
  logic       tx_en;
  logic       ir_en;

  assign op_mode       = mode_q[usid_pkg::MODE_OP_LSB +: usid_pkg::MODE_OP_W];
  assign tx_en         = mode_q[usid_pkg::MODE_TXE_BIT];
  assign ir_en         = mode_q[usid_pkg::MODE_IR_BIT];
  assign OP_MODE_O     = op_mode;
  assign TX_ENABLE_O   = tx_en;
  assign IR_MODE_O     = ir_en;
  assign TIMEOUT_VAL_O = toval_q;

  // ==========================================================================
  // Commands and write-one-to-clear on the status register
  logic                      clr_sta;
  logic                      clr_nack;
  logic                      start_to;
  logic [usid_pkg::ST_W-1:0] w1c;

  assign clr_sta  = wr_cmd & PWDATA_I[usid_pkg::CMD_CLR_STATUS];
  assign clr_nack = wr_cmd & PWDATA_I[usid_pkg::CMD_CLR_NACK];
  assign start_to = wr_cmd & PWDATA_I[usid_pkg::CMD_START_TO];
  assign w1c      = (wr & hit(PADDR_I, usid_pkg::OFF_STATUS))
                  ? PWDATA_I[usid_pkg::ST_W-1:0] : '0;

  // ==========================================================================
  // Sticky error flags: a set always beats a clear in the same cycle
  logic parity_q;
  logic replim_q;
  logic urun_q;
  logic nack_q;
  logic urun_set;

  assign urun_set = UNDERRUN_I & (op_mode == usid_pkg::OP_SPI_SLAVE);

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      parity_q <= 1'b0;
      replim_q <= 1'b0;
      urun_q   <= 1'b0;
    end else begin
      parity_q <= PARITY_ERR_I
                | (parity_q & ~clr_sta & ~w1c[usid_pkg::ST_PARITY]);
      replim_q <= REPEAT_EVT_I
                | (replim_q & ~clr_sta & ~w1c[usid_pkg::ST_REPEAT]);
      urun_q   <= urun_set
                | (urun_q & ~clr_sta & ~w1c[usid_pkg::ST_URUN]);
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      nack_q <= 1'b0;
    end else begin
      nack_q <= NACK_I
              | (nack_q & ~clr_nack & ~w1c[usid_pkg::ST_NACK]);
    end
  end

  // ==========================================================================
  // Receiver time-out, armed by the start command
  logic to_q;
  logic to_arm_q;
  logic to_set;

  assign to_set = TIMEOUT_EVT_I & to_arm_q;

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      to_q     <= 1'b0;
      to_arm_q <= 1'b0;
    end else begin
      to_arm_q <= start_to | (to_arm_q & ~TIMEOUT_EVT_I);
      to_q     <= to_set
                | (to_q & ~start_to & ~w1c[usid_pkg::ST_TO]);
    end
  end

  // ==========================================================================
  // Modem line change flags, cleared by a status read
  logic [2:0] line;
  logic [2:0] line_q;
  logic       line_vld_q;
  logic [2:0] chg_q;
  logic [2:0] chg_set;
  logic [2:0] rd_clr;
  logic       rd_done;

  assign line    = {DCD_I, DSR_I, RING_I};
  assign rd_done = acc & ~PWRITE_I & hit(PADDR_I, usid_pkg::OFF_STATUS);

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      line_q     <= 3'h0;
      line_vld_q <= 1'b0;
    end else begin
      line_q     <= line;
      line_vld_q <= 1'b1;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_chg
      assign chg_set[gi] = line_vld_q & (line[gi] ^ line_q[gi]);
      // Only bits that the read actually returned as set are cleared
      assign rd_clr[gi]  = rd_done & PRDATA_O[usid_pkg::ST_CHG + gi];
      a_chg_kept: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
        chg_set[gi] |=> chg_q[gi])
        else $error("modem line change lost");
      a_chg_clr: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
        rd_clr[gi] && !chg_set[gi] |=> !chg_q[gi])
        else $error("change flag not cleared by status read");
    end
  endgenerate

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      chg_q <= 3'h0;
    end else begin
      chg_q <= chg_set
             | (chg_q & ~rd_clr & ~w1c[usid_pkg::ST_CHG +: 3]);
    end
  end

  // ==========================================================================
  // Status word and interrupt
  logic [usid_pkg::ST_W-1:0] status;

  always_comb begin
    status                     = '0;
    status[usid_pkg::ST_PARITY] = parity_q;
    status[usid_pkg::ST_TO]    = to_q & (toval_q != '0);
    status[usid_pkg::ST_TXE]   = tx_en & THR_EMPTY_I & TSR_EMPTY_I;
    status[usid_pkg::ST_REPEAT] = replim_q;
    status[usid_pkg::ST_URUN]  = urun_q;
    status[usid_pkg::ST_TXDMA] = TX_DMA_BUF_EMPTY_I;
    status[usid_pkg::ST_RXDMA] = RX_DMA_BUF_FULL_I;
    status[usid_pkg::ST_NACK]  = nack_q;
    status[usid_pkg::ST_CHG +: 3] = chg_q;
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      IRQ_O <= 1'b0;
    end else begin
      IRQ_O <= |(status & mask_q);
    end
  end

  // ==========================================================================
  // Read data, captured in the setup phase
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      PRDATA_O <= 32'h0000_0000;
    end else if (rd_setup) begin
      PRDATA_O <= 32'h0000_0000;
      if (hit(PADDR_I, usid_pkg::OFF_MODE)) begin
        PRDATA_O[5:0] <= mode_q;
      end
      if (hit(PADDR_I, usid_pkg::OFF_STATUS)) begin
        PRDATA_O[usid_pkg::ST_W-1:0] <= status;
      end
      if (hit(PADDR_I, usid_pkg::OFF_MASK)) begin
        PRDATA_O[usid_pkg::ST_W-1:0] <= mask_q;
      end
      if (hit(PADDR_I, usid_pkg::OFF_IRFILT)) begin
        PRDATA_O[usid_pkg::IRFILT_W-1:0] <= irfilt_q;
      end
      if (hit(PADDR_I, usid_pkg::OFF_BAUD)) begin
        PRDATA_O[usid_pkg::BAUD_W-1:0] <= baud_q;
      end
      if (hit(PADDR_I, usid_pkg::OFF_TOVAL)) begin
        PRDATA_O[usid_pkg::TOVAL_W-1:0] <= toval_q;
      end
    end
  end

  // ==========================================================================
  // Infrared demodulator
  usid_ir_demod u_demod (
    .clk_i  (CLK_SYS_I),
    .rstn_i (RSTN_I),
    .ir_en_i(ir_en),
    .rxd_i  (RXD_I),
    .filt_i (irfilt_q),
    .baud_i (baud_q),
    .rxd_o  (RXD_DEMOD_O)
  );

  // ==========================================================================
  // Checks
  a_parity_hold: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    parity_q && !clr_sta && !w1c[usid_pkg::ST_PARITY] |=> parity_q)
    else $error("parity flag dropped without clear");
  a_parity_set: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    PARITY_ERR_I && clr_sta |=> parity_q)
    else $error("parity error lost against clear");
  a_to_cause: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    $rose(to_q) |-> $past(TIMEOUT_EVT_I) && $past(to_arm_q))
    else $error("timeout flag set without armed timeout");
  a_to_zero: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    rd_setup && hit(PADDR_I, usid_pkg::OFF_STATUS) && toval_q == '0
    |=> !PRDATA_O[usid_pkg::ST_TO])
    else $error("timeout reads set with zero value");
  a_txe_both: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    rd_setup && hit(PADDR_I, usid_pkg::OFF_STATUS)
    |=> PRDATA_O[usid_pkg::ST_TXE] == ($past(THR_EMPTY_I) && $past(TSR_EMPTY_I)
                                      && $past(tx_en)))
    else $error("tx empty bit wrong");
  a_repeat_set: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    REPEAT_EVT_I |=> replim_q)
    else $error("repetition flag not set");
  a_urun_mode: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    $rose(urun_q) |-> $past(op_mode) == usid_pkg::OP_SPI_SLAVE)
    else $error("underrun set outside SPI slave mode");
  a_txdma_mirror: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    rd_setup && hit(PADDR_I, usid_pkg::OFF_STATUS)
    |=> PRDATA_O[usid_pkg::ST_TXDMA] == $past(TX_DMA_BUF_EMPTY_I))
    else $error("tx buffer empty bit not mirrored");
  a_rxdma_mirror: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    rd_setup && hit(PADDR_I, usid_pkg::OFF_STATUS)
    |=> PRDATA_O[usid_pkg::ST_RXDMA] == $past(RX_DMA_BUF_FULL_I))
    else $error("rx buffer full bit not mirrored");
  a_nack_hold: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    NACK_I ##1 (!clr_nack && !w1c[usid_pkg::ST_NACK]) [*2] |=> nack_q)
    else $error("nack flag not held");
  a_irq_level: assert property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    IRQ_O == $past(|(status & mask_q)))
    else $error("interrupt does not follow masked status");

  c_chg_read: cover property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    |rd_clr && |chg_set);
  c_timeout: cover property (@(posedge CLK_SYS_I) disable iff (!RSTN_I)
    start_to ##[1:50] to_set);
  c_irq: cover property (@(posedge CLK_SYS_I) disable iff (!RSTN_I) $rose(IRQ_O));

endmodule : usid_top
`default_nettype wire

// [verification/tb.sv]
// Self-checking bench for the status flags and infrared demodulator
// Assumes the design answers APB with a constant ready
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk    = 1'b0;
  logic        rstn   = 1'b0;
  logic        psel   = 1'b0;
  logic        pen    = 1'b0;
  logic        pwr    = 1'b0;
  logic [7:0]  paddr  = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, irq, demod, rxd, err;
  logic        send   = 1'b0;
  logic [7:0]  width  = 8'h00;
  logic [4:0]  evt    = 5'h00;
  logic [1:0]  txs    = 2'b11;
  logic [1:0]  dma    = 2'b00;
  logic [2:0]  mdm    = 3'b000;
  logic [3:0]  opm;
  logic        txen, irm;
  logic [15:0] tov;
  int          err_count   = 0;
  int          comparisons = 0;
  always #5 clk = ~clk;
  usid_ir_peer peer (.clk_i(clk), .send_i(send), .width_i(width), .rxd_o(rxd));
  usid_top uut (.CLK_SYS_I(clk), .RSTN_I(rstn), .PSEL_I(psel), .PENABLE_I(pen),
    .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
    .PREADY_O(pready), .PSLVERR_O(pslverr), .PARITY_ERR_I(evt[0]),
    .TIMEOUT_EVT_I(evt[1]), .REPEAT_EVT_I(evt[2]), .UNDERRUN_I(evt[3]),
    .NACK_I(evt[4]), .THR_EMPTY_I(txs[1]), .TSR_EMPTY_I(txs[0]),
    .TX_DMA_BUF_EMPTY_I(dma[0]), .RX_DMA_BUF_FULL_I(dma[1]), .RING_I(mdm[0]),
    .DSR_I(mdm[1]), .DCD_I(mdm[2]), .RXD_I(rxd), .RXD_DEMOD_O(demod),
    .TX_ENABLE_O(txen), .IR_MODE_O(irm), .OP_MODE_O(opm), .TIMEOUT_VAL_O(tov),
    .IRQ_O(irq));
  // ==========================================================================
  // Shared tasks
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic pulse(input int b);
    @(posedge clk);
    evt[b] <= 1'b1;
    @(posedge clk);
    evt[b] <= 1'b0;
  endtask : pulse
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, usid_pkg::OFF_STATUS, 32'h0000_0000);
    chk("status", e, rd & m);
  endtask : st
  task automatic irp(input logic [7:0] w, input int e);
    int n;
    n = 0;
    @(posedge clk);
    width <= w;
    send  <= 1'b1;
    @(posedge clk);
    send <= 1'b0;
    repeat (30) begin
      @(posedge clk);
      if (demod === 1'b0) n++;
    end
    chk("demod low cycles", e, n);
  endtask : irp
  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    apb(1'b0, usid_pkg::OFF_BAUD, 32'h0000_0000);
    chk("baud", 32'h0000_0010, rd);
    apb(1'b0, usid_pkg::OFF_MASK, 32'h0000_0000);
    chk("mask", 32'h0000_0000, rd);
    apb(1'b0, 8'h40, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {rd[30:0], err});
  endtask : t_reset
  task automatic t_sticky();
    pulse(0);
    pulse(2);
    pulse(3);
    pulse(4);
    st(32'h0000_0099, 32'h0000_0089);
    st(32'h0000_0099, 32'h0000_0089);
    apb(1'b1, usid_pkg::OFF_CMD, 32'h0000_0100);
    st(32'h0000_0099, 32'h0000_0080);
    apb(1'b1, usid_pkg::OFF_CMD, 32'h0000_4000);
    st(32'h0000_0099, 32'h0000_0000);
    apb(1'b1, usid_pkg::OFF_MODE, 32'h0000_000F);
    @(negedge clk);
    chk("op mode", 32'h0000_000F, {28'h000_0000, opm});
    pulse(3);
    apb(1'b1, usid_pkg::OFF_MODE, 32'h0000_0000);
    st(32'h0000_0010, 32'h0000_0010);
    apb(1'b1, usid_pkg::OFF_CMD, 32'h0000_0100);
    st(32'h0000_0010, 32'h0000_0000);
  endtask : t_sticky
  task automatic t_timeout();
    apb(1'b1, usid_pkg::OFF_CMD, 32'h0000_0800);
    pulse(1);
    st(32'h0000_0002, 32'h0000_0000);
    apb(1'b1, usid_pkg::OFF_TOVAL, 32'h0000_0005);
    apb(1'b1, usid_pkg::OFF_CMD, 32'h0000_0800);
    chk("timeout value", 32'h0000_0005, {16'h0000, tov});
    pulse(1);
    st(32'h0000_0002, 32'h0000_0002);
    apb(1'b1, usid_pkg::OFF_CMD, 32'h0000_0800);
    st(32'h0000_0002, 32'h0000_0000);
  endtask : t_timeout
  task automatic t_tx();
    st(32'h0000_0064, 32'h0000_0000);
    apb(1'b1, usid_pkg::OFF_MODE, 32'h0000_0020);
    dma <= 2'b11;
    st(32'h0000_0064, 32'h0000_0064);
    chk("tx enable", 32'h0000_0001, {31'h0000_0000, txen});
    txs <= 2'b10;
    dma <= 2'b01;
    st(32'h0000_0064, 32'h0000_0020);
    txs <= 2'b01;
    dma <= 2'b00;
    st(32'h0000_0064, 32'h0000_0000);
  endtask : t_tx
  task automatic t_modem();
    for (int i = 0; i < 3; i++) begin
      mdm[i] <= ~mdm[i];
      st(32'h0000_0700, 32'h0000_0100 << i);
      st(32'h0000_0700, 32'h0000_0000);
    end
    fork
      apb(1'b0, usid_pkg::OFF_STATUS, 32'h0000_0000);
      begin
        repeat (1) @(posedge clk);
        mdm[1] <= ~mdm[1];
      end
    join
    chk("status", 32'h0000_0000, rd & 32'h0000_0200);
    st(32'h0000_0200, 32'h0000_0200);
  endtask : t_modem
  task automatic t_irq();
    pulse(0);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    apb(1'b1, usid_pkg::OFF_MASK, 32'h0000_0001);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("irq raised", 32'h0000_0001, {31'h0, irq});
    apb(1'b1, usid_pkg::OFF_STATUS, 32'h0000_0001);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
  endtask : t_irq
  task automatic t_ir();
    apb(1'b1, usid_pkg::OFF_IRFILT, 32'h0000_0004);
    apb(1'b1, usid_pkg::OFF_BAUD, 32'h0000_0003);
    apb(1'b1, usid_pkg::OFF_MODE, 32'h0000_0010);
    irp(8'h02, 0);
    chk("ir mode", 32'h0000_0001, {31'h0000_0000, irm});
    irp(8'h0A, 3);
    apb(1'b1, usid_pkg::OFF_MODE, 32'h0000_0000);
    irp(8'h05, 5);
  endtask : t_ir
  // ==========================================================================
  // Sequence and verdict
  task automatic tally_and_finish();
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_sticky();
    t_timeout();
    t_tx();
    t_modem();
    t_irq();
    t_ir();
    tally_and_finish();
  end
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire

// [verification/usid_ir_peer.sv]
// Remote infrared transmitter model that drives the receive line
// Assumes send requests are synchronous to the system clock
`timescale 1ns/1ps
`default_nettype none
module usid_ir_peer (
  input  wire logic       clk_i,
  input  wire logic       send_i,
  input  wire logic [7:0] width_i,
  output logic            rxd_o
);
  logic [7:0] left_q = 8'h00;
  // Line idles high; a request pulls it low for width_i clocks
  always_ff @(posedge clk_i) begin
    if (send_i) begin
      left_q <= width_i;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
    end
  end
  assign rxd_o = (left_q == 8'h00);
endmodule : usid_ir_peer
`default_nettype wire
